// File: include/gate_spi_pkg.sv
// Purpose: shared constants of the gate driver serial register port
// Assumes: 16-bit frames, 11-bit registers, 4-bit addresses
// Notes:   every offset, field position and reset value lives here
`default_nettype none
package gate_spi_pkg;
  // frame layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned DATA_BITS  = 11;
  localparam int unsigned ADDR_BITS  = 4;
  localparam int unsigned RNW_POS    = 15;          // read_not_write_bit
  localparam int unsigned ADDR_HI    = 14;
  localparam int unsigned ADDR_LO    = 11;
  localparam logic [4:0]  VALID_CNT  = 5'h10;       // falling edges in a good frame
  localparam logic [4:0]  CNT_MAX    = 5'h1F;       // counter saturates here
  localparam logic [4:0]  LAUNCH_CNT = 5'h05;       // rises before data bit 10 goes out
  // register offsets
  localparam logic [3:0] WARN_ADDR  = 4'h1;
  localparam logic [3:0] OVDS_ADDR  = 4'h2;
  localparam logic [3:0] CHIP_ADDR  = 4'h3;
  localparam logic [3:0] VGS_ADDR   = 4'h4;
  localparam logic [3:0] HS_ADDR    = 4'h5;
  localparam logic [3:0] LS_ADDR    = 4'h6;
  localparam logic [3:0] TIME_ADDR  = 4'h7;
  localparam logic [3:0] RSVD_ADDR  = 4'h8;
  localparam logic [3:0] OP_ADDR    = 4'h9;
  localparam logic [3:0] SHUNT_ADDR = 4'hA;
  localparam logic [3:0] REG_ADDR   = 4'hB;
  localparam logic [3:0] DSNS_ADDR  = 4'hC;
  // warning register field positions
  localparam int unsigned FAULT_POS = 10;
  localparam int unsigned TMAX_POS  = 8;
  localparam int unsigned SUV_POS   = 7;
  localparam int unsigned SOV_POS   = 6;
  localparam int unsigned DOC_POS   = 5;
  localparam int unsigned PUV_POS   = 4;
  localparam int unsigned TLOW_POS  = 3;
  localparam int unsigned TMID_POS  = 2;
  localparam int unsigned THIGH_POS = 1;
  localparam int unsigned OTW_POS   = 0;
  // operation register fields
  localparam int unsigned CLR_POS   = 1;            // fault_clear_bit
  localparam int unsigned WDEN_POS  = 3;            // watchdog_enable_bit
  // control register reset values
  localparam logic [10:0] HS_RST    = 11'h344;
  localparam logic [10:0] LS_RST    = 11'h000;
  localparam logic [10:0] TIME_RST  = 11'h000;
  localparam logic [10:0] OP_RST    = 11'h000;
  localparam logic [10:0] SHUNT_RST = 11'h000;
  localparam logic [10:0] REG_RST   = 11'h000;
  localparam logic [10:0] DSNS_RST  = 11'h000;
  localparam logic [10:0] ZERO_WORD = 11'h000;
endpackage
`default_nettype wire

// File: hdl/gate_driver_spi_register_port.sv
// Purpose: serial register port of a three-phase gate driver
// Assumes: serialClk comes from the master, mode 0/1, 16-bit frames
// Notes:   frame logic runs on serialClk, register file on clk
//
// Functional notes
// - slave only; 5-bit command plus 11 data
// - response: 11 data bits low, top five zero
// - clock idles low, sample on trailing edge
// - exactly 16 clocks, else frame discarded
// - launch on rising, sample on falling edge
// - both words shift most significant first
// - deselected: inputs ignored, output released
// - bit 15 zero writes, one reads
// - bits 14:11 address, 10:0 write data
// - write answers with previous register content
// - read answers content, leaves register alone
// - status registers 1 to 4 read-only
// - warning register access kicks the watchdog
// - warning bit 5 live OR of overcurrents
// - four temperature flags, bits 3,2,1,8
// - supply, pump, overtemperature warning bits placed
// - control registers default at reset, sleep entry
// - fault clear bit pulses, then self-clears
`default_nettype none
module gate_driver_spi_register_port (
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // serial link from the master
  input  wire logic        serialClk,
  input  wire logic        chipSelectN,
  input  wire logic        serialIn,
  output logic             serialOut,
  output logic             serialOutEn,
  // analog monitors, asynchronous to clk
  input  wire logic        faultPresent,
  input  wire logic        tempFlagLow,
  input  wire logic        tempFlagMid,
  input  wire logic        tempFlagHigh,
  input  wire logic        tempFlagMax,
  input  wire logic        supplyUndervoltageWarn,
  input  wire logic        supplyOvervoltageWarn,
  input  wire logic        pumpUndervoltageWarn,
  input  wire logic        overtemperatureWarn,
  input  wire logic [5:0]  drainOvercurrent,
  input  wire logic [10:0] overvoltageDrainFaults,
  input  wire logic [10:0] chipFaults,
  input  wire logic [10:0] gateVoltageFaults,
  // device state machine, same clock
  input  wire logic        sleepEntry,
  // control outputs
  output logic [10:0]      highSideDriveCtrl,
  output logic [10:0]      lowSideDriveCtrl,
  output logic [10:0]      driveTimingCtrl,
  output logic [10:0]      chipOperationCtrl,
  output logic [10:0]      shuntAmpCtrl,
  output logic [10:0]      regulatorCtrl,
  output logic [10:0]      drainSenseCtrl,
  // event pulses
  output logic             faultClearPulse,
  output logic             watchdogKick,
  output logic             frameError
);

  // link domain state
  logic        frameIdle;              // select high or reset: start marker and launch logic parked
  logic        freshQ;                 // next falling edge starts a frame
  logic [15:0] inShiftQ;               // received bits, newest in bit 0
  logic [4:0]  fallCntQ;               // falling edges seen in this frame
  logic [4:0]  riseCntQ;               // rising edges seen in this frame
  logic [9:0]  outShiftQ;              // response bits still to launch
  logic        serialOutQ;             // bit on the wire
  // clk domain state
  logic        csMetaQ;                // first synchroniser stage
  logic        csSyncQ;                // synchronised select
  logic        csPrevQ;                // for edge detection
  logic        serialOutEnQ;           // output enable
  logic [15:0] wordQ;                  // captured command word
  logic [4:0]  cntQ;                   // captured edge count
  logic        commitQ;                // one-cycle commit strobe
  logic [47:0] statMetaQ;              // status inputs, stage one
  logic [47:0] statSyncQ;              // status inputs, stage two
  logic [10:0] snapQ [0:15];           // frozen register view for the frame
  logic [10:0] regView [0:15];         // live register view
  logic [10:0] ctrlView [0:15];        // control register flops
  logic [10:0] warnView;               // assembled warning register
  logic        faultClearQ;
  logic        watchdogKickQ;
  logic        frameErrorQ;
  logic        csFall;
  logic        csRise;
  logic        validFrame;
  logic        commitWrite;
  logic [3:0]  cmdAddr;
  logic [10:0] cmdData;

  // select high parks the start marker and launch logic, not the sampling flops; also covers system reset
  assign frameIdle = chipSelectN | ~rst_b;

  // frame start marker, set while deselected
  always_ff @(negedge serialClk or posedge frameIdle) begin
    if (frameIdle) begin
      freshQ <= 1'b1;
    end else begin
      freshQ <= 1'b0;
    end
  end

  // sample on falling edge, msb first; word and count survive deselect
  // so the clk side can read them after the frame ends
  always_ff @(negedge serialClk or negedge rst_b) begin
    if (!rst_b) begin
      inShiftQ <= 16'h0000;
      fallCntQ <= 5'h00;
    end else begin
      inShiftQ <= {inShiftQ[14:0], serialIn};
      if (freshQ) begin
        fallCntQ <= 5'h01;
      end else if (fallCntQ != gate_spi_pkg::CNT_MAX) begin
        fallCntQ <= fallCntQ + 5'h01;
      end
    end
  end

  // launch on rising edge; snapQ is frozen for the whole frame, so
  // reading it here at the sixth rise is safe despite the other clock
  always_ff @(posedge serialClk or posedge frameIdle) begin
    if (frameIdle) begin
      riseCntQ   <= 5'h00;
      outShiftQ  <= 10'h000;
      serialOutQ <= 1'b0;
    end else begin
      if (riseCntQ != gate_spi_pkg::CNT_MAX) begin
        riseCntQ <= riseCntQ + 5'h01;
      end
      if (riseCntQ == gate_spi_pkg::LAUNCH_CNT) begin
        // address bits arrived on falls two to five
        {serialOutQ, outShiftQ} <= snapQ[inShiftQ[3:0]];
      end else if (riseCntQ > gate_spi_pkg::LAUNCH_CNT) begin
        // keeps shifting even if the frame turns out bad
        serialOutQ <= outShiftQ[9];
        outShiftQ  <= {outShiftQ[8:0], 1'b0};
      end else begin
        serialOutQ <= 1'b0;                         // don't-care bits as zero
      end
    end
  end

  assign serialOut = serialOutQ;

  // select synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csMetaQ <= 1'b1;
      csSyncQ <= 1'b1;
      csPrevQ <= 1'b1;
    end else begin
      csMetaQ <= chipSelectN;
      csSyncQ <= csMetaQ;
      csPrevQ <= csSyncQ;
    end
  end

  assign csFall = csPrevQ & ~csSyncQ;
  assign csRise = ~csPrevQ & csSyncQ;

  // output enable follows synchronised select, a few cycles late
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serialOutEnQ <= 1'b0;
    end else begin
      serialOutEnQ <= ~csSyncQ;
    end
  end

  assign serialOutEn = serialOutEnQ;

  // status inputs come from analog, two flops before use; the overcurrent
  // lines are ORed only after the second stage, so no gate sees a raw pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statMetaQ <= '0;
      statSyncQ <= '0;
    end else begin
      statMetaQ <= {faultPresent, tempFlagMax, supplyUndervoltageWarn, supplyOvervoltageWarn,
                    drainOvercurrent, pumpUndervoltageWarn, tempFlagLow, tempFlagMid,
                    tempFlagHigh, overtemperatureWarn,
                    overvoltageDrainFaults, chipFaults, gateVoltageFaults};
      statSyncQ <= statMetaQ;
    end
  end

  // warning register layout; the overcurrent bit is not latched
  always_comb begin
    warnView = gate_spi_pkg::ZERO_WORD;  // reserved bit 9 stays zero
    warnView[gate_spi_pkg::FAULT_POS] = statSyncQ[47];
    warnView[gate_spi_pkg::TMAX_POS]  = statSyncQ[46];
    warnView[gate_spi_pkg::SUV_POS]   = statSyncQ[45];
    warnView[gate_spi_pkg::SOV_POS]   = statSyncQ[44];
    warnView[gate_spi_pkg::DOC_POS]   = |statSyncQ[43:38];
    warnView[gate_spi_pkg::PUV_POS]   = statSyncQ[37];
    warnView[gate_spi_pkg::TLOW_POS]  = statSyncQ[36];
    warnView[gate_spi_pkg::TMID_POS]  = statSyncQ[35];
    warnView[gate_spi_pkg::THIGH_POS] = statSyncQ[34];
    warnView[gate_spi_pkg::OTW_POS]   = statSyncQ[33];
  end

  // live register view; holes read as zero
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      regView[i] = ctrlView[i];
    end
    regView[gate_spi_pkg::WARN_ADDR] = warnView;
    regView[gate_spi_pkg::OVDS_ADDR] = statSyncQ[32:22];
    regView[gate_spi_pkg::CHIP_ADDR] = statSyncQ[21:11];
    regView[gate_spi_pkg::VGS_ADDR]  = statSyncQ[10:0];
  end

  // freeze the view at frame start: a write answers with old data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) begin
        snapQ[i] <= gate_spi_pkg::ZERO_WORD;
      end
    end else if (csFall) begin
      for (int i = 0; i < 16; i++) begin
        snapQ[i] <= regView[i];
      end
    end
  end

  // frame end: link is idle, so word and count are stable to copy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wordQ   <= 16'h0000;
      cntQ    <= 5'h00;
      commitQ <= 1'b0;
    end else begin
      commitQ <= csRise;
      if (csRise) begin
        wordQ <= inShiftQ;
        cntQ  <= fallCntQ;
      end
    end
  end

  assign validFrame  = commitQ && (cntQ == gate_spi_pkg::VALID_CNT);
  assign commitWrite = validFrame && !wordQ[gate_spi_pkg::RNW_POS];
  assign cmdAddr     = wordQ[gate_spi_pkg::ADDR_HI:gate_spi_pkg::ADDR_LO];
  assign cmdData     = wordQ[10:0];

  // one flop set per writable address; the rest give a zero ctrlView entry
  for (genvar a = 0; a < 16; a++) begin : g_ctrl
    localparam logic [3:0] AD = 4'(a);
    if (a >= 5 && a <= 12 && a != 8) begin : g_rw
      localparam logic [10:0] RV = (a == 5) ? gate_spi_pkg::HS_RST :
                                   (a == 6) ? gate_spi_pkg::LS_RST :
                                   (a == 7) ? gate_spi_pkg::TIME_RST :
                                   (a == 9) ? gate_spi_pkg::OP_RST :
                                   (a == 10) ? gate_spi_pkg::SHUNT_RST :
                                   (a == 11) ? gate_spi_pkg::REG_RST : gate_spi_pkg::DSNS_RST;
      logic [10:0] q;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          q <= RV;
        end else if (sleepEntry) begin
          q <= RV;
        end else if (commitWrite && cmdAddr == AD) begin
          q <= cmdData;
        end else if (AD == gate_spi_pkg::OP_ADDR && q[gate_spi_pkg::CLR_POS]) begin
          q[gate_spi_pkg::CLR_POS] <= 1'b0;
        end
      end
      assign ctrlView[a] = q;
    end else begin : g_ro
      assign ctrlView[a] = gate_spi_pkg::ZERO_WORD;
    end
  end

  // event pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      faultClearQ   <= 1'b0;
      watchdogKickQ <= 1'b0;
      frameErrorQ   <= 1'b0;
    end else begin
      faultClearQ   <= ctrlView[gate_spi_pkg::OP_ADDR][gate_spi_pkg::CLR_POS];
      watchdogKickQ <= validFrame && cmdAddr == gate_spi_pkg::WARN_ADDR;
      frameErrorQ   <= commitQ && !validFrame;
    end
  end

  assign faultClearPulse   = faultClearQ;
  assign watchdogKick      = watchdogKickQ;
  assign frameError        = frameErrorQ;
  assign highSideDriveCtrl = ctrlView[gate_spi_pkg::HS_ADDR];
  assign lowSideDriveCtrl  = ctrlView[gate_spi_pkg::LS_ADDR];
  assign driveTimingCtrl   = ctrlView[gate_spi_pkg::TIME_ADDR];
  assign chipOperationCtrl = ctrlView[gate_spi_pkg::OP_ADDR];
  assign shuntAmpCtrl      = ctrlView[gate_spi_pkg::SHUNT_ADDR];
  assign regulatorCtrl     = ctrlView[gate_spi_pkg::REG_ADDR];
  assign drainSenseCtrl    = ctrlView[gate_spi_pkg::DSNS_ADDR];

  // checks
  property p_write_lands;
    @(posedge clk) disable iff (!rst_b)
    commitWrite && cmdAddr == gate_spi_pkg::HS_ADDR && !sleepEntry |=> highSideDriveCtrl == $past(cmdData);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write data not stored");

  property p_read_keeps;
    @(posedge clk) disable iff (!rst_b)
    validFrame && wordQ[15] && !sleepEntry |=> $stable(highSideDriveCtrl) && $stable(drainSenseCtrl);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read altered a register");

  property p_error_keeps;
    @(posedge clk) disable iff (!rst_b)
    commitQ && cntQ != 5'h10 && !sleepEntry |=> $stable(lowSideDriveCtrl) && $stable(shuntAmpCtrl) && frameError;
  endproperty
  a_error_keeps: assert property (p_error_keeps) else $error("bad frame acted on");

  property p_ro_write;
    @(posedge clk) disable iff (!rst_b)
    commitWrite && (cmdAddr < 4'h5 || cmdAddr > 4'hC || cmdAddr == 4'h8) && !sleepEntry
      |=> $stable(driveTimingCtrl) && $stable(regulatorCtrl);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

  property p_clear_self;
    @(posedge clk) disable iff (!rst_b)
    commitWrite && cmdAddr == 4'h9 && cmdData[1] && !sleepEntry
      |=> chipOperationCtrl[1] ##1 (!chipOperationCtrl[1] && faultClearPulse) ##1 !faultClearPulse;
  endproperty
  a_clear_self: assert property (p_clear_self) else $error("fault clear did not pulse");

  property p_kick;
    @(posedge clk) disable iff (!rst_b)
    validFrame && cmdAddr == 4'h1 |=> watchdogKick ##1 !watchdogKick;
  endproperty
  a_kick: assert property (p_kick) else $error("watchdog not kicked");

  property p_sleep_default;
    @(posedge clk) disable iff (!rst_b)
    sleepEntry |=> highSideDriveCtrl == 11'h344 && chipOperationCtrl == 11'h000;
  endproperty
  a_sleep_default: assert property (p_sleep_default) else $error("sleep kept control values");

  property p_live_or;
    @(posedge clk) disable iff (!rst_b)
    csFall |=> snapQ[1][5] == $past(|statSyncQ[43:38]) && snapQ[1][9] == 1'b0;
  endproperty
  a_live_or: assert property (p_live_or) else $error("warning snapshot wrong");

  property p_oe;
    @(posedge clk) disable iff (!rst_b)
    csRise |=> !serialOutEn;
  endproperty
  a_oe: assert property (p_oe) else $error("output driven while deselected");

  property p_head_zero;
    @(posedge serialClk) disable iff (frameIdle)
    riseCntQ < 5'h05 |=> !serialOut;
  endproperty
  a_head_zero: assert property (p_head_zero) else $error("don't-care bits not zero");

  c_write: cover property (@(posedge clk) disable iff (!rst_b) commitWrite);
  c_read: cover property (@(posedge clk) disable iff (!rst_b) validFrame && wordQ[15]);
  c_error: cover property (@(posedge clk) disable iff (!rst_b) frameError);

endmodule
`default_nettype wire

// File: test/spi_master_model.sv
// Purpose: behavioural serial bus master that talks to the register port
// Assumes: mode 0/1 framing, link clock half period 80 ns, select falls at a clk fall, rises 3.3 ns after one
// Notes:   the link clock only runs inside frames; stray() breaks that on purpose
`default_nettype none
module spi_master_model (
  // system clock, only used to place select edges
  input  wire logic clk,
  // serial link toward the device
  output logic      serialClk,
  output logic      chipSelectN,
  output logic      serialIn,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam time HALF = 80ns;   // half of the 160 ns link period
  localparam time GAP  = 700ns;  // idle select time, covers the commit latency too

  // link idles with clock low and select high
  initial begin
    serialClk   = 1'b0;
    chipSelectN = 1'b1;
    serialIn    = 1'b0;
  end

  // one frame of nbits clocks; bits beyond sixteen are sent as zero
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] resp);
    resp = 16'h0000;
    @(negedge clk);
    chipSelectN = 1'b0;                              // clock is low at this edge
    #(3.3ns);                                        // skew keeps link edges off the clk edges
    for (int i = 0; i < nbits; i++) begin
      #(HALF);
      serialClk = 1'b1;
      serialIn  = (i < 16) ? word[15 - i] : 1'b0;    // launch on rise, msb first
      #(HALF);
      serialClk = 1'b0;
      resp      = {resp[14:0], serialOut};           // capture on fall
    end
    #(HALF);
    chipSelectN = 1'b1;                              // clock still low, frame length decided
    serialIn    = ~serialIn;                         // released line must not show the last bit
    #(GAP);                                          // deselected gap of at least 500 ns
  endtask

  // clock and data wiggle with select high; the device must ignore them
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      #(HALF) serialClk = ~serialClk;
      serialIn = ~serialIn;
    end
    serialClk = 1'b0;
    #(HALF);
  endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Purpose: self-checking bench for the gate driver serial register port
// Assumes: master model drives the link, monitors are random from a fixed lfsr
// Notes:   expectations come from a register shadow kept by the bench
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // clock, reset and link
  logic        clk, rst_b, serialClk, chipSelectN, serialIn, serialOut, serialOutEn;
  // monitor inputs
  logic        faultPresent, tempFlagLow, tempFlagMid, tempFlagHigh, tempFlagMax;
  logic        supplyUndervoltageWarn, supplyOvervoltageWarn, pumpUndervoltageWarn, overtemperatureWarn;
  logic [5:0]  drainOvercurrent;
  logic [10:0] overvoltageDrainFaults, chipFaults, gateVoltageFaults;
  logic        sleepEntry;
  // control outputs and event pulses
  logic [10:0] highSideDriveCtrl, lowSideDriveCtrl, driveTimingCtrl, chipOperationCtrl;
  logic [10:0] shuntAmpCtrl, regulatorCtrl, drainSenseCtrl;
  logic        faultClearPulse, watchdogKick, frameError;
  // bench state
  int          errors, cmpCount, cycleCount;
  int          kickSeen, errSeen, clearSeen, expKick, expErr, expClear;
  logic [15:0] lfsrQ;                 // random source, starts at 85
  logic [10:0] regModel [16];         // shadow of the control registers

  gate_driver_spi_register_port dut (
    .clk(clk), .rst_b(rst_b), .serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .faultPresent(faultPresent),
    .tempFlagLow(tempFlagLow), .tempFlagMid(tempFlagMid), .tempFlagHigh(tempFlagHigh),
    .tempFlagMax(tempFlagMax), .supplyUndervoltageWarn(supplyUndervoltageWarn),
    .supplyOvervoltageWarn(supplyOvervoltageWarn), .pumpUndervoltageWarn(pumpUndervoltageWarn),
    .overtemperatureWarn(overtemperatureWarn), .drainOvercurrent(drainOvercurrent),
    .overvoltageDrainFaults(overvoltageDrainFaults), .chipFaults(chipFaults),
    .gateVoltageFaults(gateVoltageFaults), .sleepEntry(sleepEntry),
    .highSideDriveCtrl(highSideDriveCtrl), .lowSideDriveCtrl(lowSideDriveCtrl),
    .driveTimingCtrl(driveTimingCtrl), .chipOperationCtrl(chipOperationCtrl), .shuntAmpCtrl(shuntAmpCtrl),
    .regulatorCtrl(regulatorCtrl), .drainSenseCtrl(drainSenseCtrl), .faultClearPulse(faultClearPulse),
    .watchdogKick(watchdogKick), .frameError(frameError)
  );

  spi_master_model master (
    .clk(clk), .serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn)
  );

  // 100 MHz system clock
  always #5 clk = ~clk;

  // timeout and event pulse counting share the system clock
  always @(posedge clk) begin
    cycleCount++;
    if (frameError === 1'b1) errSeen++;
    if (watchdogKick === 1'b1) kickSeen++;
    if (faultClearPulse === 1'b1) clearSeen++;
    if (cycleCount == 60000) begin
      errors++;
      tally_and_finish();
    end
  end

  // output must be driven whenever the master samples inside a frame
  always @(negedge serialClk) if (chipSelectN === 1'b0) check_flag(serialOutEn, 1'b1);

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic is_ctrl(input logic [3:0] a);
    return a >= gate_spi_pkg::HS_ADDR && a <= gate_spi_pkg::DSNS_ADDR && a != gate_spi_pkg::RSVD_ADDR;
  endfunction

  // warning word built from the monitor levels, bit 9 always zero
  function automatic logic [10:0] warn_word();
    return {faultPresent, 1'b0, tempFlagMax, supplyUndervoltageWarn, supplyOvervoltageWarn,
            |drainOvercurrent, pumpUndervoltageWarn, tempFlagLow, tempFlagMid, tempFlagHigh,
            overtemperatureWarn};
  endfunction

  // what a frame to address a must answer
  function automatic logic [10:0] exp_word(input logic [3:0] a);
    case (a)
      gate_spi_pkg::WARN_ADDR: return warn_word();
      gate_spi_pkg::OVDS_ADDR: return overvoltageDrainFaults;
      gate_spi_pkg::CHIP_ADDR: return chipFaults;
      gate_spi_pkg::VGS_ADDR:  return gateVoltageFaults;
      default:                 return is_ctrl(a) ? regModel[a] : gate_spi_pkg::ZERO_WORD;
    endcase
  endfunction

  function automatic logic [10:0] got_ctrl(input logic [3:0] a);
    case (a)
      gate_spi_pkg::HS_ADDR:    return highSideDriveCtrl;
      gate_spi_pkg::LS_ADDR:    return lowSideDriveCtrl;
      gate_spi_pkg::TIME_ADDR:  return driveTimingCtrl;
      gate_spi_pkg::SHUNT_ADDR: return shuntAmpCtrl;
      gate_spi_pkg::REG_ADDR:   return regulatorCtrl;
      gate_spi_pkg::DSNS_ADDR:  return drainSenseCtrl;
      default:                  return chipOperationCtrl;
    endcase
  endfunction

  task automatic reset_model();
    foreach (regModel[i]) regModel[i] = gate_spi_pkg::ZERO_WORD;
    regModel[gate_spi_pkg::HS_ADDR] = gate_spi_pkg::HS_RST;
  endtask

  task automatic report(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0d ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [15:0] got, input logic [15:0] exp);
    report(got, exp);
  endtask

  task automatic check_ctrl(input logic [10:0] got, input logic [10:0] exp);
    report({5'h00, got}, {5'h00, exp});
  endtask

  task automatic check_flag(input logic got, input logic exp);
    report({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic check_count(input int got, input int exp);
    report(16'(got), 16'(exp));
  endtask

  // new random monitor levels, then let the synchronisers settle
  task automatic shake_monitors();
    @(negedge clk);
    lfsrQ = lfsr_next(lfsrQ);
    {faultPresent, tempFlagLow, tempFlagMid, tempFlagHigh, tempFlagMax, supplyUndervoltageWarn,
     supplyOvervoltageWarn, pumpUndervoltageWarn, overtemperatureWarn} = lfsrQ[8:0];
    drainOvercurrent       = lfsrQ[15:10] & {lfsrQ[0], 5'h1F};
    overvoltageDrainFaults = {lfsrQ[4:0], lfsrQ[15:10]};
    chipFaults             = lfsrQ[12:2];
    gateVoltageFaults      = lfsrQ[10:0] ^ 11'h5A5;
    repeat (6) @(negedge clk);
  endtask

  // one frame plus every comparison that follows from it
  task automatic access(input logic rnw, input logic [3:0] a, input logic [10:0] d, input int nbits);
    logic [15:0] resp;
    logic [15:0] expResp;
    expResp = {5'h00, exp_word(a)};
    master.xfer({rnw, a, d}, nbits, resp);
    if (nbits != 16) begin
      expErr++;
    end else begin
      check_resp(resp, expResp);
      if (a == gate_spi_pkg::WARN_ADDR) expKick++;
      if (!rnw && is_ctrl(a)) begin
        regModel[a] = d;
        if (a == gate_spi_pkg::OP_ADDR && d[gate_spi_pkg::CLR_POS]) begin
          regModel[a][gate_spi_pkg::CLR_POS] = 1'b0;
          expClear++;
        end
      end
    end
    if (is_ctrl(a)) check_ctrl(got_ctrl(a), regModel[a]);
    check_flag(serialOutEn, 1'b0);
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    sleepEntry = 1'b0;
    lfsrQ = 16'h0055;
    {faultPresent, tempFlagLow, tempFlagMid, tempFlagHigh, tempFlagMax, supplyUndervoltageWarn,
     supplyOvervoltageWarn, pumpUndervoltageWarn, overtemperatureWarn} = 9'h000;
    drainOvercurrent = 6'h00;
    overvoltageDrainFaults = 11'h000;
    chipFaults = 11'h000;
    gateVoltageFaults = 11'h000;
    reset_model();
    repeat (5) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    repeat (4) @(negedge clk);
    // whole map read after reset with moving status inputs
    for (int a = 0; a < 16; a++) begin
      shake_monitors();
      access(1'b1, 4'(a), 11'h7FF, 16);
    end
    // random reads and writes anywhere, back to back
    for (int k = 0; k < 16; k++) begin
      shake_monitors();
      access(lfsrQ[9], lfsrQ[14:11], {lfsrQ[3:0], lfsrQ[15:9]}, 16);
    end
    access(1'b0, gate_spi_pkg::LS_ADDR, 11'h7FF, 16);
    access(1'b0, gate_spi_pkg::LS_ADDR, 11'h000, 16);
    access(1'b0, gate_spi_pkg::CHIP_ADDR, 11'h7FF, 16);
    access(1'b0, gate_spi_pkg::RSVD_ADDR, 11'h7FF, 16);
    access(1'b0, gate_spi_pkg::OP_ADDR, 11'h00A, 16);
    access(1'b1, gate_spi_pkg::OP_ADDR, 11'h000, 16);
    // short and long frames, then stray link activity while deselected
    access(1'b0, gate_spi_pkg::HS_ADDR, 11'h123, 15);
    access(1'b0, gate_spi_pkg::HS_ADDR, 11'h321, 17);
    master.stray(9);
    access(1'b1, gate_spi_pkg::HS_ADDR, 11'h000, 16);
    // sleep entry returns every control register to its default
    @(negedge clk) sleepEntry = 1'b1;
    @(negedge clk) sleepEntry = 1'b0;
    reset_model();
    for (int a = 5; a < 13; a++) access(1'b1, 4'(a), 11'h000, 16);
    check_count(kickSeen, expKick);
    check_count(errSeen, expErr);
    check_count(clearSeen, expClear);
    tally_and_finish();
  end
endmodule
`default_nettype wire
